/* shared/sweep_consts.vh */
`ifndef SWEEP_CONSTS_VH
`define SWEEP_CONSTS_VH
// ==========================================================
// serial word layout
`define WORD_BITS 16
`define ADDR_MSB 15
`define ADDR_LSB 12
`define ADDR_CONTROL 4'h0
`define DATA_MSB 11
// ==========================================================
// control field positions inside the 12 data bits
`define F_LOAD24 11
`define F_DAC_EN 10
`define F_SINE 9
`define F_MSB_PIN_EN 8
`define F_CONT_GATED 7
`define F_GATE_SRC 6
`define F_STEP_SRC 5
`define F_PROFILE 4
`define F_SYNC_EVT 3
`define F_SYNC_PIN_EN 2
`define CTRL_RESET 12'h003
// ==========================================================
// timing
`define SYNC_PULSE_CLKS 3'h4
`define BIT_CNT_LAST 4'hf
`endif

/* hw/pin_sync3.v */
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter RST_VAL = 1'b0
) (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_pin,
  output reg o_level
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  // ==========================================================
  // three stages, change accepted when stage two and three agree
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      o_level <= RST_VAL;
    end
    else
    begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        o_level <= s3_ff;
    end
  end
endmodule
`default_nettype wire

/* hw/serial_word_rx.v */
`timescale 1ns/1ps
`default_nettype none
`include "sweep_consts.vh"
module serial_word_rx (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_sclk,
  input wire i_sdata,
  input wire i_frame_n,
  output reg o_word_valid,
  output reg [`WORD_BITS-1:0] o_word
);
  reg sclk_prev_ff;
  reg [3:0] bit_cnt_ff;
  reg [`WORD_BITS-1:0] shift_ff;
  wire fall = sclk_prev_ff & ~i_sclk;
  // ==========================================================
  // shift msb first on falling serial clock while frame is low
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sclk_prev_ff <= 1'b1;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 16'h0000;
      o_word_valid <= 1'b0;
      o_word <= 16'h0000;
    end
    else
    begin
      sclk_prev_ff <= i_sclk;
      o_word_valid <= 1'b0;
      if (i_frame_n)
        bit_cnt_ff <= 4'h0; // partial word dropped
      else if (fall)
      begin
        shift_ff <= {shift_ff[`WORD_BITS-2:0], i_sdata};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (bit_cnt_ff == `BIT_CNT_LAST)
        begin
          o_word_valid <= 1'b1;
          o_word <= {shift_ff[`WORD_BITS-2:0], i_sdata};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* hw/sweep_mode_control.v */
`timescale 1ns/1ps
`default_nettype none
`include "sweep_consts.vh"
// Contract
// - control selected by address nibble zero
// - msb pin tri-state when its enable clear
// - continuous mode outputs whole step window
// - gated mode outputs only burst length
// - rest of window held at midscale
// - external steps: window set by trigger
// - gate source only when gated, external step
// - external gate: trigger level gates burst
// - internal gate: burst counted from length
// - internal stepping ignores gate source
// - external stepping advances on trigger edge
// - internal stepping advances on interval expiry
// - profile one: sawtooth, restart after last
// - profile zero: up then down sweep
// - sync high at sweep end until next
// - sync four-clock pulse on up step
// - sync enable drives sync pin
// - sync pin tri-state when disabled
module sweep_mode_control (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_sclk,
  input wire i_sdata,
  input wire i_frame_n,
  input wire i_trigger_pin,
  input wire i_cycle_tick,
  input wire i_interval_in_cycles,
  input wire i_burst_in_cycles,
  input wire [10:0] i_step_interval,
  input wire [10:0] i_burst_len,
  input wire [11:0] i_step_count,
  input wire i_phase_msb,
  output reg o_msb_digital_output,
  output reg o_msb_oe,
  output reg o_sync_output_pin,
  output reg o_sync_oe,
  output reg o_midscale,
  output reg o_step_up,
  output reg o_step_down,
  output reg o_sweep_restart,
  output reg [11:0] o_step_index,
  output reg o_running,
  output reg o_load24,
  output reg o_dac_enable,
  output reg o_sine_select
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;
  // ==========================================================
  // pin synchronisers and serial receiver
  wire sclk_s;
  wire sdata_s;
  wire frame_n_s;
  wire trig_s;
  wire word_valid;
  wire [`WORD_BITS-1:0] word;
  pin_sync3 #(.RST_VAL(1'b1)) u_sync_sclk (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_sclk),
    .o_level(sclk_s)
  );
  pin_sync3 #(.RST_VAL(1'b0)) u_sync_sdata (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_sdata),
    .o_level(sdata_s)
  );
  pin_sync3 #(.RST_VAL(1'b1)) u_sync_frame (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_frame_n),
    .o_level(frame_n_s)
  );
  pin_sync3 #(.RST_VAL(1'b0)) u_sync_trig (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_trigger_pin),
    .o_level(trig_s)
  );
  serial_word_rx u_rx (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_sclk(sclk_s),
    .i_sdata(sdata_s),
    .i_frame_n(frame_n_s),
    .o_word_valid(word_valid),
    .o_word(word)
  );
  // ==========================================================
  // control register
  reg [`DATA_MSB:0] sweep_control_ff;
  // load only on a complete word carrying address zero
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      sweep_control_ff <= `CTRL_RESET;
    else if (word_valid && word[`ADDR_MSB:`ADDR_LSB] == `ADDR_CONTROL)
      sweep_control_ff <= word[`DATA_MSB:0]; // low two bits kept as written
  end
  wire continuous_or_gated = sweep_control_ff[`F_CONT_GATED];
  wire gate_source_select = sweep_control_ff[`F_GATE_SRC];
  wire step_trigger_source = sweep_control_ff[`F_STEP_SRC];
  wire saw_profile = sweep_control_ff[`F_PROFILE];
  wire sync_event_select = sweep_control_ff[`F_SYNC_EVT];
  // external gate only in gated mode with external stepping
  wire gate_external = ~continuous_or_gated & step_trigger_source & gate_source_select;
  // ==========================================================
  // trigger edge detect
  reg trig_prev_ff;
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      trig_prev_ff <= 1'b0;
    else
      trig_prev_ff <= trig_s;
  end
  wire trig_rise = trig_s & ~trig_prev_ff;
  // ==========================================================
  // window and burst timing
  reg state_ff;
  reg [10:0] win_cnt_ff;
  reg [10:0] burst_cnt_ff;
  wire win_tick = i_interval_in_cycles ? i_cycle_tick : 1'b1;
  wire burst_tick = i_burst_in_cycles ? i_cycle_tick : 1'b1;
  wire interval_done = win_tick && (win_cnt_ff >= i_step_interval - 11'h001);
  reg advance;
  // step source choice
  always @*
  begin
    advance = 1'b0;
    if (state_ff == ST_RUN)
    begin
      if (step_trigger_source)
        advance = trig_rise;
      else
        advance = interval_done;
    end
  end
  reg live;
  // waveform live or held at midscale
  always @*
  begin
    if (continuous_or_gated)
      live = 1'b1;
    else if (gate_external)
      live = trig_s;
    else
      live = burst_cnt_ff < i_burst_len;
  end
  // window and burst counters restart on each step
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_ff <= ST_IDLE;
      win_cnt_ff <= 11'h000;
      burst_cnt_ff <= 11'h000;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          win_cnt_ff <= 11'h000;
          burst_cnt_ff <= 11'h000;
          if (trig_rise)
            state_ff <= ST_RUN;
        end
        ST_RUN:
        begin
          if (advance)
          begin
            win_cnt_ff <= 11'h000;
            burst_cnt_ff <= 11'h000;
          end
          else
          begin
            if (win_tick && !interval_done)
              win_cnt_ff <= win_cnt_ff + 11'h001;
            if (burst_tick && burst_cnt_ff < i_burst_len)
              burst_cnt_ff <= burst_cnt_ff + 11'h001;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // sweep profile
  reg [11:0] idx_ff;
  reg dir_down_ff;
  reg [11:0] nxt_idx;
  reg nxt_dir_down;
  reg up_step;
  reg down_step;
  reg restart;
  // next position, direction and step events
  always @*
  begin
    nxt_idx = idx_ff;
    nxt_dir_down = dir_down_ff;
    up_step = 1'b0;
    down_step = 1'b0;
    restart = 1'b0;
    if (advance)
    begin
      if (saw_profile)
      begin
        nxt_dir_down = 1'b0;
        if (idx_ff >= i_step_count)
        begin
          nxt_idx = 12'h000;
          restart = 1'b1;
        end
        else
        begin
          nxt_idx = idx_ff + 12'h001;
          up_step = 1'b1;
        end
      end
      else if (!dir_down_ff)
      begin
        if (idx_ff >= i_step_count)
        begin
          nxt_dir_down = 1'b1;
          nxt_idx = idx_ff - 12'h001;
          down_step = 1'b1;
        end
        else
        begin
          nxt_idx = idx_ff + 12'h001;
          up_step = 1'b1;
        end
      end
      else if (idx_ff == 12'h000)
      begin
        nxt_dir_down = 1'b0;
        nxt_idx = 12'h001;
        up_step = 1'b1;
        restart = 1'b1;
      end
      else
      begin
        nxt_idx = idx_ff - 12'h001;
        down_step = 1'b1;
      end
    end
  end
  // end of sweep: saw at last step, triangle back at start
  wire at_end = saw_profile ? (nxt_idx >= i_step_count) : (nxt_dir_down && nxt_idx == 12'h000);
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      idx_ff <= 12'h000;
      dir_down_ff <= 1'b0;
    end
    else
    begin
      idx_ff <= nxt_idx;
      dir_down_ff <= nxt_dir_down;
    end
  end
  // ==========================================================
  // sync event generation
  reg end_of_sweep_ff;
  reg [2:0] pulse_cnt_ff;
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      end_of_sweep_ff <= 1'b0;
      pulse_cnt_ff <= 3'h0;
    end
    else
    begin
      if (advance)
        end_of_sweep_ff <= at_end;
      if (up_step)
        pulse_cnt_ff <= `SYNC_PULSE_CLKS;
      else if (pulse_cnt_ff != 3'h0)
        pulse_cnt_ff <= pulse_cnt_ff - 3'h1;
    end
  end
  // ==========================================================
  // registered outputs
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_msb_digital_output <= 1'b0;
      o_msb_oe <= 1'b0;
      o_sync_output_pin <= 1'b0;
      o_sync_oe <= 1'b0;
      o_midscale <= 1'b1;
      o_step_up <= 1'b0;
      o_step_down <= 1'b0;
      o_sweep_restart <= 1'b0;
      o_step_index <= 12'h000;
      o_running <= 1'b0;
      o_load24 <= 1'b0;
      o_dac_enable <= 1'b0;
      o_sine_select <= 1'b0;
    end
    else
    begin
      o_msb_digital_output <= i_phase_msb;
      o_msb_oe <= sweep_control_ff[`F_MSB_PIN_EN];
      if (sync_event_select)
        o_sync_output_pin <= end_of_sweep_ff;
      else
        o_sync_output_pin <= (pulse_cnt_ff != 3'h0);
      o_sync_oe <= sweep_control_ff[`F_SYNC_PIN_EN];
      o_midscale <= (state_ff != ST_RUN) | ~live;
      o_step_up <= up_step;
      o_step_down <= down_step;
      o_sweep_restart <= restart;
      o_step_index <= nxt_idx;
      o_running <= (state_ff == ST_RUN);
      o_load24 <= sweep_control_ff[`F_LOAD24];
      o_dac_enable <= sweep_control_ff[`F_DAC_EN];
      o_sine_select <= sweep_control_ff[`F_SINE];
    end
  end
endmodule
`default_nettype wire

/* test/sweep_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sweep_checker (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [11:0] i_step_count,
  input wire logic i_phase_msb,
  input wire logic o_msb_digital_output,
  input wire logic o_msb_oe,
  input wire logic o_sync_output_pin,
  input wire logic o_step_up,
  input wire logic o_step_down,
  input wire logic o_sweep_restart,
  input wire logic [11:0] o_step_index
);
  // ====
  // step and sync relations
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  wire logic adv = o_step_up | o_step_down | o_sweep_restart;
  sequence s_sync_hi4;
    o_sync_output_pin [*4];
  endsequence
  a_one_advance: assert property (!(o_step_down && (o_step_up || o_sweep_restart)))
    else $error("down step together with up or restart");
  a_up_index: assert property (o_step_up |-> o_step_index == $past(o_step_index) + 12'h001)
    else $error("up step index wrong");
  a_down_index: assert property (o_step_down |-> o_step_index == $past(o_step_index) - 12'h001)
    else $error("down step index wrong");
  a_up_limit: assert property (o_step_up |-> o_step_index <= i_step_count)
    else $error("step beyond last");
  a_restart_low: assert property (o_sweep_restart |-> o_step_index <= 12'h001)
    else $error("restart index wrong");
  a_index_hold: assert property (!adv |-> $stable(o_step_index))
    else $error("index moved without advance");
  a_msb_copy: assert property (o_msb_oe |-> o_msb_digital_output == $past(i_phase_msb))
    else $error("msb output wrong");
  a_sync_width: assert property ($rose(o_sync_output_pin) |-> s_sync_hi4)
    else $error("sync pulse too short");
endmodule
`default_nettype wire

/* test/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic i_sys_clk,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_frame_n,
  output logic o_trigger
);
  // ====
  // idle levels, serial clock stands low
  initial
  begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_frame_n = 1'b1;
    o_trigger = 1'b0;
  end
  // word writer, msb first, five clocks a phase
  task automatic send(input logic [15:0] w, input int nbits);
    @(posedge i_sys_clk);
    o_frame_n <= 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      o_sclk <= 1'b1;
      o_sdata <= w[15 - i];
      repeat (5) @(posedge i_sys_clk);
      o_sclk <= 1'b0;
      repeat (5) @(posedge i_sys_clk);
    end
    o_frame_n <= 1'b1;
    o_sdata <= ~o_sdata;
    repeat (12) @(posedge i_sys_clk);
  endtask
  // trigger level held for n clocks
  task automatic level(input logic v, input int n);
    @(posedge i_sys_clk);
    o_trigger <= v;
    repeat (n) @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

/* test/test_sweep_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_sweep_mode_control;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic tick_w = 1'b0;
  logic phase = 1'b0;
  logic [11:0] n_incr = 12'h003;
  logic [31:0] lfsr = 32'h0000_082d;
  wire logic sclk, sdata, frame_n, trig, msb_do, msb_oe, sync_o, sync_oe, mid;
  wire logic up, dn, rs, run, l24, dac, sine;
  wire logic [11:0] idx;
  wire logic [11:0] pins = {7'h000, l24, dac, sine, msb_oe, sync_oe};
  int errors = 0;
  int n_compared = 0;
  int saw, p, per, e, n_adv, mode, tc;
  logic cyc = 1'b0;
  logic tk_prev = 1'b0;
  // ====
  // clock and random inputs
  always #2 i_sys_clk = ~i_sys_clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge i_sys_clk)
  begin
    lfsr <= lfsr_next(lfsr);
    tick_w <= lfsr[3];
    phase <= lfsr[7];
  end
  host_model hst (.i_sys_clk(i_sys_clk), .o_sclk(sclk), .o_sdata(sdata), .o_frame_n(frame_n), .o_trigger(trig));
  sweep_mode_control uut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_sclk(sclk), .i_sdata(sdata),
    .i_frame_n(frame_n), .i_trigger_pin(trig), .i_cycle_tick(tick_w), .i_interval_in_cycles(cyc),
    .i_burst_in_cycles(cyc), .i_step_interval(11'h008), .i_burst_len(11'h003), .i_step_count(n_incr),
    .i_phase_msb(phase), .o_msb_digital_output(msb_do), .o_msb_oe(msb_oe), .o_sync_output_pin(sync_o),
    .o_sync_oe(sync_oe), .o_midscale(mid), .o_step_up(up), .o_step_down(dn), .o_sweep_restart(rs),
    .o_step_index(idx), .o_running(run), .o_load24(l24), .o_dac_enable(dac), .o_sine_select(sine));
  // ====
  // compare and report
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // bench model of step position, window length and burst midscale
  always @(negedge i_sys_clk)
    if (i_arst_n)
    begin
      if (mode != 0 && n_adv > 0)
        check("mid", {11'h000, mid}, {11'h000, mode == 2 && tc >= 3});
      tc = tc + tk_prev; // units seen at the edge just passed
      tk_prev = cyc ? tick_w : 1'b1;
      if (up | dn | rs)
      begin
        if (mode != 0 && n_adv > 0)
          check("window", 12'(tc), 12'h008);
        tc = 0;
        per = saw ? n_incr + 1 : 2 * n_incr;
        p = (p + 1) % per;
        e = (saw != 0 || p <= n_incr) ? p : 2 * n_incr - p;
        check("index", idx, 12'(e));
        n_adv++;
      end
    end
  // ====
  // helpers
  task automatic do_reset(input int sw);
    i_arst_n <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    saw = sw;
    p = 0;
    n_adv = 0;
    mode = 0;
    repeat (6) @(posedge i_sys_clk);
  endtask
  task automatic ctrl(input logic [11:0] f);
    hst.send({4'h0, f[11:2], 2'b11}, 16);
    @(negedge i_sys_clk);
  endtask
  task automatic wait_adv(input int k);
    for (int t = 0; t < 2000 && n_adv < k; t++)
      @(posedge i_sys_clk);
    if (n_adv < k)
    begin
      errors++;
      conclude();
    end
  endtask
  // ====
  // scenarios
  initial
  begin
    do_reset(1);
    @(negedge i_sys_clk);
    check("mid rst", {10'h000, run, mid}, 12'h001);
    mode = 1;
    check("pins rst", pins, 12'h000);
    ctrl(12'hf97);
    check("pins on", pins, 12'h01f);
    hst.send(16'h1000, 16);
    hst.send(16'h0000, 9);
    @(negedge i_sys_clk);
    check("pins kept", pins, 12'h01f);
    hst.level(1'b1, 6);
    hst.level(1'b0, 6);
    wait_adv(2 * n_incr + 3);
    @(negedge i_sys_clk);
    check("cont mid", {11'h000, mid}, 12'h000);
    check("running", {11'h000, run}, 12'h001);
    do_reset(0);
    ctrl(12'h02f);
    check("msb off", pins, 12'h001);
    hst.level(1'b1, 6);
    hst.level(1'b0, 30);
    for (int i = 0; i < 8; i++)
    begin
      hst.level(1'b1, 6);
      hst.level(1'b0, 30);
      @(negedge i_sys_clk);
      check("ext steps", 12'(n_adv), 12'(i + 1));
      check("burst mid", {11'h000, mid}, 12'h001);
      if (i >= 5)
        check("eos", {11'h000, sync_o}, {11'h000, i == 5});
    end
    do_reset(0);
    ctrl(12'h06f);
    hst.level(1'b1, 40);
    @(negedge i_sys_clk);
    check("gate hi", {11'h000, mid}, 12'h000);
    hst.level(1'b0, 40);
    @(negedge i_sys_clk);
    check("gate lo", {11'h000, mid}, 12'h001);
    // gated, internal steps, gate source set but ignored, units in output cycles
    do_reset(1);
    cyc <= 1'b1;
    mode = 2;
    ctrl(12'h053);
    hst.level(1'b1, 6);
    hst.level(1'b0, 6);
    wait_adv(6);
    conclude();
  end
endmodule
bind sweep_mode_control sweep_checker chk (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
  .i_step_count(i_step_count), .i_phase_msb(i_phase_msb), .o_msb_digital_output(o_msb_digital_output),
  .o_msb_oe(o_msb_oe), .o_sync_output_pin(o_sync_output_pin), .o_step_up(o_step_up),
  .o_step_down(o_step_down), .o_sweep_restart(o_sweep_restart), .o_step_index(o_step_index));
`default_nettype wire
